//--- logic/tsec_consts.svh
// Purpose: shared constants of the two-stage event controller
// Assumes: included by bare name from every design file
// Notes: event numbers double as priorities, 0 is the highest
`ifndef TSEC_CONSTS_SVH
`define TSEC_CONSTS_SVH

`define TSEC_NUM_EVT 16
`define TSEC_NUM_SRC 48
`define TSEC_NUM_GP 9

`define TSEC_EVT_EMU 4'h0
`define TSEC_EVT_RST 4'h1
`define TSEC_EVT_NMI 4'h2
`define TSEC_EVT_EXC 4'h3
`define TSEC_EVT_RSVD 4'h4
`define TSEC_EVT_HWE 4'h5
`define TSEC_EVT_TMR 4'h6
`define TSEC_EVT_GP_FIRST 4'h7
`define TSEC_NO_EVT 5'h10

// first source index of each default level block from level 8 to 13
`define TSEC_SRC_L8_FIRST 15
`define TSEC_SRC_L9_FIRST 17
`define TSEC_SRC_L10_FIRST 25
`define TSEC_SRC_L11_FIRST 34
`define TSEC_SRC_L12_FIRST 41
`define TSEC_SRC_L13_FIRST 43

// reset values and fixed control mask bits
`define TSEC_PMASK_RST 48'h0000_0000_0000
`define TSEC_CMASK_RST 16'h000F
`define TSEC_CMASK_FIXED_ON 16'h000F
`define TSEC_CMASK_FIXED_OFF 16'h0010

`endif

//--- logic/tsec_pkg.sv
// Purpose: types of the two-stage event controller
// Assumes: tsec_consts.svh for widths
// Notes: all module state is carried in these packed structs
`include "tsec_consts.svh"

package tsec_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TAKE = 2'b01
  } tsec_fsm_t;

  typedef enum logic [1:0] {
    SEL_ASSIGN = 2'b00,
    SEL_PMASK = 2'b01,
    SEL_CMASK = 2'b10,
    SEL_LATCH = 2'b11
  } tsec_cfg_sel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    tsec_cfg_sel_t sel;
    logic [5:0] index;
    logic [31:0] data;
  } tsec_cfg_req_t;

  typedef struct packed {
    logic req;
    logic [3:0] event_vector_table;
    logic saveState;
  } tsec_take_t;

  typedef struct packed {
    logic [`TSEC_NUM_EVT-1:0] sample;
    logic [`TSEC_NUM_EVT-1:0] prev;
    logic [`TSEC_NUM_EVT-1:0] latch;
  } tsec_edge_state_t;

  typedef struct packed {
    logic [`TSEC_NUM_EVT-1:0][31:0] mem;
    logic [31:0] rd;
  } tsec_mem_state_t;

  typedef struct packed {
    tsec_fsm_t fsm;
    logic [`TSEC_NUM_SRC-1:0][3:0] srcLevel;
    logic [`TSEC_NUM_SRC-1:0] pmask;
    logic [`TSEC_NUM_SRC-1:0] perStatus;
    logic [`TSEC_NUM_EVT-1:0] cmask;
    logic [`TSEC_NUM_EVT-1:0] pending;
    logic [`TSEC_NUM_GP-1:0] gpLevels;
    logic [1:0] nmiSync;
    tsec_take_t take;
    logic commitHold;
    logic emuMode;
    logic retValid;
    logic [31:0] rdData;
    logic denied;
  } tsec_core_state_t;

endpackage : tsec_pkg

//--- logic/tsec_edge_latch.sv
// Purpose: rising-edge detect and latch for the sixteen core event inputs
// Assumes: inputs are on clk; pins are synchronised by the caller
// Notes: a new edge or direct set beats a clear in the same cycle
`timescale 1ns/100ps
`include "tsec_consts.svh"

module tsec_edge_latch
  import tsec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // event side
  input wire logic [`TSEC_NUM_EVT-1:0] level,
  input wire logic [`TSEC_NUM_EVT-1:0] directSet,
  input wire logic [`TSEC_NUM_EVT-1:0] clr,
  // latched events
  output logic [`TSEC_NUM_EVT-1:0] latch
);

  tsec_edge_state_t st_ff;
  tsec_edge_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sample = level;
    nxt_st.prev = st_ff.sample;
    // sample then compare: two cycles from input rise to latch
    nxt_st.latch = (st_ff.latch & ~clr) | (st_ff.sample & ~st_ff.prev) | directSet; // RULE21 RULE22
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign latch = st_ff.latch;

endmodule : tsec_edge_latch

//--- logic/tsec_ret_store.sv
// Purpose: one return address per event type
// Assumes: single write and single read port on clk
// Notes: read data appear one cycle after the read strobe
`timescale 1ns/100ps
`include "tsec_consts.svh"

module tsec_ret_store
  import tsec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // write port
  input wire logic wrEn,
  input wire logic [3:0] wrIdx,
  input wire logic [31:0] wrData,
  // read port
  input wire logic rdEn,
  input wire logic [3:0] rdIdx,
  output logic [31:0] rdData
);

  tsec_mem_state_t st_ff;
  tsec_mem_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (wrEn) begin
      nxt_st.mem[wrIdx] = wrData; // RULE8
    end
    if (rdEn) begin
      nxt_st.rd = st_ff.mem[rdIdx];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdData = st_ff.rd;

endmodule : tsec_ret_store

//--- logic/tsec_event_ctrl.sv
// Purpose: two-stage event controller, system routing stage plus core ranking stage
// Assumes: peripheral sources and sequencer on clk; nmiPin is an asynchronous pin
// Notes: configuration is a plain request port gated by supervisor mode
// Behaviour
// (RULE1) core events ranked 0 highest to 15: emu, reset, nmi, exception, reserved, ...
// (RULE2) nine general-purpose levels exist beside the dedicated events
// (RULE3) software should keep levels 14 and 15 for software handlers
// (RULE4) higher priority event preempts an active lower one; routines nest
// (RULE5) of pending events, the higher priority one is serviced first
// (RULE6) nmi raised by watchdog request or external nmi pin
// (RULE7) exception is taken before the faulting instruction completes
// (RULE8) each event type keeps its own return address
// (RULE9) taking an event asks the sequencer to save state on supervisor stack
// (RULE10) peripheral sources enter the system stage and drive a general level
// (RULE11) default level map after reset; software writes change the assignment
// (RULE12) pll wake-up and error sources default to level 7; rtc, parallel port dma to 8
// (RULE13) serial port receive and transmit dma sources default to level 9
// (RULE14) spi dma and uart receive and transmit dma default to level 10
// (RULE15) timers, two-wire ports, can receive and transmit default to level 11
// (RULE16) port f gpio sources a and b default to level 12
// (RULE17) memory dma streams and watchdog default to level 13
// (RULE18) control registers reachable only in supervisor mode, never by peripherals
// (RULE19) emulation event puts the processor into emulation mode
// (RULE20) interrupts come from pins, timers, peripherals and a software raise
// (RULE21) latch bit sets on a detected rising edge, detection takes two cycles
// (RULE22) latch clears when pending sets; the next edge is then queued
// (RULE23) general input rise to pending takes at least three cycles
// (RULE24) a source is forwarded only while its peripheral mask bit is set
// (RULE25) a level is asserted while any unmasked source assigned to it asserts
// (RULE26) reserved priority slot 4 is never raised
`timescale 1ns/100ps
`include "tsec_consts.svh"

module tsec_event_ctrl
  import tsec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // peripheral and core event sources
  input wire logic [`TSEC_NUM_SRC-1:0] perSrc,
  input wire logic wdogNmi,
  input wire logic nmiPin,
  input wire logic emuReq,
  input wire logic rstEvtReq,
  input wire logic hwErrReq,
  input wire logic coreTimerReq,
  // sequencer side
  input wire logic excReq,
  input wire logic swRaise,
  input wire logic [3:0] swRaiseLvl,
  input wire logic globalEnable,
  input wire logic takeAck,
  input wire logic [31:0] curPc,
  input wire logic retStrobe,
  input wire logic [3:0] retEvt,
  output tsec_take_t take,
  output logic commitHold,
  output logic emuMode,
  output logic returnValid,
  output logic [31:0] returnAddr,
  output logic [`TSEC_NUM_EVT-1:0] pendingOut,
  output logic [`TSEC_NUM_EVT-1:0] latchOut,
  // configuration access
  input wire logic supervisor,
  input wire logic periphAccess,
  input wire tsec_cfg_req_t cfgReq,
  output logic [31:0] cfgRdData,
  output logic cfgDenied,
  // system stage status
  output logic [`TSEC_NUM_SRC-1:0] perStatus,
  output logic [`TSEC_NUM_GP-1:0] gpLevels
);

  function automatic logic [3:0] defaultLevel(input int src);
    logic [3:0] lvl;
    lvl = 4'h7; // RULE12
    if (src >= `TSEC_SRC_L8_FIRST) lvl = 4'h8; // RULE12
    if (src >= `TSEC_SRC_L9_FIRST) lvl = 4'h9; // RULE13
    if (src >= `TSEC_SRC_L10_FIRST) lvl = 4'hA; // RULE14
    if (src >= `TSEC_SRC_L11_FIRST) lvl = 4'hB; // RULE15
    if (src >= `TSEC_SRC_L12_FIRST) lvl = 4'hC; // RULE16
    if (src >= `TSEC_SRC_L13_FIRST) lvl = 4'hD; // RULE17
    return lvl;
  endfunction : defaultLevel

  function automatic logic [`TSEC_NUM_SRC-1:0][3:0] defaultMap();
    logic [`TSEC_NUM_SRC-1:0][3:0] m;
    m = '0;
    for (int s = 0; s < `TSEC_NUM_SRC; s++) begin
      m[s] = defaultLevel(s);
    end
    return m;
  endfunction : defaultMap

  // lowest set index wins, so the scan runs from the top down
  function automatic logic [4:0] firstSet(input logic [`TSEC_NUM_EVT-1:0] v);
    logic [4:0] idx;
    idx = `TSEC_NO_EVT;
    for (int i = `TSEC_NUM_EVT - 1; i >= 0; i--) begin
      if (v[i]) idx = 5'(i);
    end
    return idx;
  endfunction : firstSet

  // sources come up blocked so nothing fires before software sets their peripheral mask bits
  localparam tsec_core_state_t RESET_ST = '{
    fsm: ST_IDLE,
    srcLevel: defaultMap(),
    pmask: `TSEC_PMASK_RST,
    perStatus: '0,
    cmask: `TSEC_CMASK_RST,
    pending: '0,
    gpLevels: '0,
    nmiSync: '0,
    take: '0,
    commitHold: 1'b0,
    emuMode: 1'b0,
    retValid: 1'b0,
    rdData: 32'h0000_0000,
    denied: 1'b0
  };

  tsec_core_state_t st_ff;
  tsec_core_state_t nxt_st;

  logic [`TSEC_NUM_SRC-1:0] fwdSrc;
  logic [`TSEC_NUM_GP-1:0][`TSEC_NUM_SRC-1:0] levelHit;
  logic [`TSEC_NUM_GP-1:0] gpHit;
  logic [`TSEC_NUM_EVT-1:0] evtLevel;
  logic [`TSEC_NUM_EVT-1:0] directSet;
  logic [`TSEC_NUM_EVT-1:0] latchClr;
  logic [`TSEC_NUM_EVT-1:0] latch;
  logic [`TSEC_NUM_EVT-1:0] enab;
  logic [`TSEC_NUM_EVT-1:0] cand;
  logic [4:0] bestIdx;
  logic [4:0] topActive;
  logic canTake;
  logic nmiLevel;
  logic cfgOk;
  logic takeDone;
  logic retHit;

  // system stage: mask, then route each source to its assigned level
  assign fwdSrc = perSrc & st_ff.pmask; // RULE24

  genvar gl;
  genvar gs;
  generate
    for (gl = 0; gl < `TSEC_NUM_GP; gl++) begin : g_level
      for (gs = 0; gs < `TSEC_NUM_SRC; gs++) begin : g_src
        assign levelHit[gl][gs] = fwdSrc[gs] &&
          (st_ff.srcLevel[gs] == 4'(gl + 7)); // RULE10
      end
      assign gpHit[gl] = |levelHit[gl]; // RULE25
    end
  endgenerate

  // core stage inputs; exception and software raise bypass edge detection
  // the watchdog request is on clk already; only the pin is synchronised
  assign nmiLevel = st_ff.nmiSync[1] | wdogNmi; // RULE6
  assign evtLevel = {st_ff.gpLevels, coreTimerReq, hwErrReq, 1'b0, 1'b0,
                     nmiLevel, rstEvtReq, emuReq}; // RULE20 RULE26

  always_comb begin
    directSet = '0;
    directSet[`TSEC_EVT_EXC] = excReq; // RULE7
    if (swRaise && (swRaiseLvl >= `TSEC_EVT_GP_FIRST)) begin
      directSet[swRaiseLvl] = 1'b1; // RULE20
    end
  end

  assign cfgOk = supervisor && !periphAccess; // RULE18
  assign takeDone = (st_ff.fsm == ST_TAKE) && takeAck;
  assign retHit = retStrobe && st_ff.pending[retEvt];

  always_comb begin
    latchClr = '0;
    if (takeDone) begin
      latchClr[st_ff.take.event_vector_table] = 1'b1; // RULE22
    end
    // software may cancel a latched event only while it is masked
    if (cfgReq.wr && cfgOk && (cfgReq.sel == SEL_LATCH)) begin
      latchClr = latchClr | (cfgReq.data[15:0] & ~st_ff.cmask);
    end
  end

  // a level held high after its take does not latch again until it drops
  tsec_edge_latch u_edge (
    .clk(clk),
    .reset_n(reset_n),
    .level(evtLevel),
    .directSet(directSet),
    .clr(latchClr),
    .latch(latch)
  );

  // unmaskable events always enabled; general levels also need global enable
  always_comb begin
    enab = st_ff.cmask;
    enab[3:0] = 4'hF;
    enab[`TSEC_EVT_RSVD] = 1'b0; // RULE26
    enab[15:7] = st_ff.cmask[15:7] & {`TSEC_NUM_GP{globalEnable}}; // RULE2
  end

  assign cand = latch & enab;
  assign bestIdx = firstSet(cand); // RULE1 RULE5
  assign topActive = firstSet(st_ff.pending);
  // only a strictly higher priority than every active routine may nest
  assign canTake = (bestIdx < topActive); // RULE4

  // return address written on the ack edge, read back on a return strobe
  tsec_ret_store u_ret (
    .clk(clk),
    .reset_n(reset_n),
    .wrEn(takeDone),
    .wrIdx(st_ff.take.event_vector_table),
    .wrData(curPc),
    .rdEn(retHit),
    .rdIdx(retEvt),
    .rdData(returnAddr)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.denied = 1'b0;
    nxt_st.retValid = 1'b0;
    // raw sources, so software can still see a masked requester
    nxt_st.perStatus = perSrc;
    nxt_st.gpLevels = gpHit; // RULE25
    nxt_st.nmiSync = {st_ff.nmiSync[0], nmiPin};
    // hold retirement while an exception waits to be taken
    nxt_st.commitHold = excReq || latch[`TSEC_EVT_EXC] ||
      (st_ff.take.req && (st_ff.take.event_vector_table == `TSEC_EVT_EXC) && !takeAck); // RULE7

    // return: free the slot first so an ack to the same slot still sets it
    if (retHit) begin
      nxt_st.pending[retEvt] = 1'b0;
      nxt_st.retValid = 1'b1; // RULE8
      if (retEvt == `TSEC_EVT_EMU) begin
        nxt_st.emuMode = 1'b0;
      end
    end

    unique case (st_ff.fsm)
      ST_IDLE: begin
        if (canTake) begin
          nxt_st.take.req = 1'b1;
          nxt_st.take.event_vector_table = bestIdx[3:0]; // RULE5
          nxt_st.take.saveState = 1'b1; // RULE9
          nxt_st.fsm = ST_TAKE;
        end
      end
      ST_TAKE: begin
        if (takeAck) begin
          nxt_st.pending[st_ff.take.event_vector_table] = 1'b1; // RULE22 RULE23
          nxt_st.take.req = 1'b0;
          nxt_st.take.saveState = 1'b0;
          nxt_st.fsm = ST_IDLE;
          if (st_ff.take.event_vector_table == `TSEC_EVT_EMU) begin
            nxt_st.emuMode = 1'b1; // RULE19
          end
        end
      end
    endcase

    // configuration writes
    // assignments below level 7 are dropped, not clipped to a legal level
    if (cfgReq.wr && cfgOk) begin
      unique case (cfgReq.sel)
        SEL_ASSIGN: begin
          if ((cfgReq.index < 6'(`TSEC_NUM_SRC)) &&
              (cfgReq.data[3:0] >= `TSEC_EVT_GP_FIRST)) begin
            nxt_st.srcLevel[cfgReq.index] = cfgReq.data[3:0]; // RULE11
          end
        end
        SEL_PMASK: begin
          if (cfgReq.index[0]) begin
            nxt_st.pmask[47:32] = cfgReq.data[15:0]; // RULE24
          end else begin
            nxt_st.pmask[31:0] = cfgReq.data; // RULE24
          end
        end
        SEL_CMASK: begin
          nxt_st.cmask = (cfgReq.data[15:0] | `TSEC_CMASK_FIXED_ON) &
            ~`TSEC_CMASK_FIXED_OFF;
        end
        SEL_LATCH: begin
          nxt_st.cmask = st_ff.cmask;
        end
      endcase
    end

    // configuration reads
    if (cfgReq.rd && cfgOk) begin
      unique case (cfgReq.sel)
        SEL_ASSIGN: begin
          if (cfgReq.index < 6'(`TSEC_NUM_SRC)) begin
            nxt_st.rdData = {28'h000_0000, st_ff.srcLevel[cfgReq.index]};
          end else begin
            nxt_st.rdData = 32'h0000_0000;
          end
        end
        SEL_PMASK: begin
          if (cfgReq.index[0]) begin
            nxt_st.rdData = {16'h0000, st_ff.pmask[47:32]};
          end else begin
            nxt_st.rdData = st_ff.pmask[31:0];
          end
        end
        SEL_CMASK: begin
          nxt_st.rdData = {16'h0000, st_ff.cmask};
        end
        SEL_LATCH: begin
          nxt_st.rdData = {st_ff.pending, latch};
        end
      endcase
    end

    // user-mode or peripheral access does nothing but flag itself
    if ((cfgReq.wr || cfgReq.rd) && !cfgOk) begin
      nxt_st.denied = 1'b1; // RULE18
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_ff <= RESET_ST; // RULE11
    end else begin
      st_ff <= nxt_st;
    end
  end

  // every output below is a register or the edge latch register
  assign take = st_ff.take;
  assign commitHold = st_ff.commitHold;
  assign emuMode = st_ff.emuMode;
  assign returnValid = st_ff.retValid;
  assign pendingOut = st_ff.pending;
  assign latchOut = latch;
  assign cfgRdData = st_ff.rdData;
  assign cfgDenied = st_ff.denied;
  assign perStatus = st_ff.perStatus;
  assign gpLevels = st_ff.gpLevels;

endmodule : tsec_event_ctrl

//--- tb/tsec_seq_model.sv
// Purpose: sequencer partner that accepts offered core events
// Assumes: take is registered by the controller on clk
// Notes: curPc encodes the event number so each return address is traceable
`timescale 1ns/100ps

module tsec_seq_model
  import tsec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // behaviour select
  input wire logic slow,
  // controller side
  input wire tsec_take_t take,
  output logic takeAck,
  output logic [31:0] curPc
);
  logic [1:0] waitCnt;

  // state save is modelled as the ack that accepts a saveState offer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      takeAck <= 1'b0;
      waitCnt <= 2'h0;
    end else if (take.req && take.saveState && !takeAck) begin
      if (!slow || waitCnt == 2'h3) begin
        takeAck <= 1'b1;
        waitCnt <= 2'h0;
      end else begin
        waitCnt <= waitCnt + 2'h1;
      end
    end else begin
      takeAck <= 1'b0;
    end
  end

  // outside the ack cycle the address is scrambled, never left meaningful
  assign curPc = takeAck ? (32'hC0DE_0000 | take.event_vector_table) : ~(32'hC0DE_0000 | take.event_vector_table);
endmodule : tsec_seq_model

//--- tb/tsec_event_ctrl_properties.sv
// Purpose: temporal checks on the event controller ports
// Assumes: bound into tsec_event_ctrl, one clock domain
// Notes: event numbers are priorities, lower wins
`timescale 1ns/100ps

module tsec_event_ctrl_properties
  import tsec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // watched ports
  input wire logic emuReq,
  input wire logic takeAck,
  input wire logic retStrobe,
  input wire logic [3:0] retEvt,
  input wire logic supervisor,
  input wire logic periphAccess,
  input wire tsec_cfg_req_t cfgReq,
  input wire tsec_take_t take,
  input wire logic emuMode,
  input wire logic returnValid,
  input wire logic [15:0] pendingOut,
  input wire logic [15:0] latchOut,
  input wire logic cfgDenied
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_rsvd; !pendingOut[4] && !latchOut[4]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved slot raised");
  property p_stand; take.req && !takeAck |=> take.req && $stable(take.event_vector_table); endproperty
  a_stand: assert property (p_stand) else $error("offer changed before ack");
  property p_ack; take.req && takeAck |=> !take.req && pendingOut[$past(take.event_vector_table)]; endproperty
  a_ack: assert property (p_ack) else $error("ack did not make event active");
  property p_save; take.saveState == take.req; endproperty
  a_save: assert property (p_save) else $error("state save not requested");
  property p_prio; $rose(take.req) |-> 16'(pendingOut << (4'hF - take.event_vector_table)) == 16'h0; endproperty
  a_prio: assert property (p_prio) else $error("offer not above active");
  property p_emu; take.req && takeAck && take.event_vector_table == 4'h0 |=> emuMode; endproperty
  a_emu: assert property (p_emu) else $error("emulation mode missing");
  property p_ret; retStrobe && pendingOut[retEvt] |=> returnValid && !pendingOut[$past(retEvt)];
  endproperty
  a_ret: assert property (p_ret) else $error("return not served");
  property p_edge; $rose(latchOut[0]) |-> $past(emuReq, 2) && !$past(emuReq, 3); endproperty
  a_edge: assert property (p_edge) else $error("latch not two cycles after edge");
  property p_deny; (cfgReq.wr || cfgReq.rd) && (!supervisor || periphAccess) |=> cfgDenied;
  endproperty
  a_deny: assert property (p_deny) else $error("access not denied");
endmodule : tsec_event_ctrl_properties

bind tsec_event_ctrl tsec_event_ctrl_properties i_props (.clk(clk), .reset_n(reset_n),
  .emuReq(emuReq), .takeAck(takeAck), .retStrobe(retStrobe), .retEvt(retEvt),
  .supervisor(supervisor), .periphAccess(periphAccess), .cfgReq(cfgReq), .take(take),
  .emuMode(emuMode), .returnValid(returnValid), .pendingOut(pendingOut),
  .latchOut(latchOut), .cfgDenied(cfgDenied));

//--- tb/tsec_event_ctrl_bench.sv
// Purpose: self-checking bench of the event controller
// Assumes: sequencer partner acks offers, fast or slow
// Notes: default map rows first, then masking, access and core events
`timescale 1ns/100ps

module tsec_event_ctrl_bench
  import tsec_pkg::*;
;
  typedef struct packed {logic [5:0] src; logic [8:0] gp;} tsec_row_t;
  tsec_row_t rows [14] = '{'{6'h00, 9'h001}, '{6'h0E, 9'h001}, '{6'h0F, 9'h002},
    '{6'h10, 9'h002}, '{6'h11, 9'h004}, '{6'h18, 9'h004}, '{6'h19, 9'h008},
    '{6'h21, 9'h008}, '{6'h22, 9'h010}, '{6'h28, 9'h010}, '{6'h29, 9'h020},
    '{6'h2A, 9'h020}, '{6'h2B, 9'h040}, '{6'h2F, 9'h040}};
  logic [3:0] evts [8] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h5, 4'h6, 4'hF};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [47:0] perSrc = '0;
  logic [7:0] kick = '0;
  logic [3:0] swRaiseLvl = 4'hF;
  logic [3:0] retEvt = 4'h0;
  logic globalEnable = 1'b0, retStrobe = 1'b0, supervisor = 1'b1, periphAccess = 1'b0;
  logic slow = 1'b0;
  tsec_cfg_req_t cfgReq = '0;
  logic emuReq, rstEvtReq, wdogNmi, nmiPin, excReq, hwErrReq, coreTimerReq, swRaise;
  logic takeAck, commitHold, emuMode, returnValid, cfgDenied;
  logic [31:0] curPc, returnAddr, cfgRdData;
  tsec_take_t take;
  logic [15:0] pendingOut, latchOut;
  logic [47:0] perStatus;
  logic [8:0] gpLevels;
  int fails = 0, comparisons = 0, cycles = 0;

  assign {swRaise, coreTimerReq, hwErrReq, excReq, nmiPin, wdogNmi, rstEvtReq, emuReq} = kick;

  tsec_event_ctrl i_dut (.clk(clk), .reset_n(reset_n), .perSrc(perSrc), .wdogNmi(wdogNmi),
    .nmiPin(nmiPin), .emuReq(emuReq), .rstEvtReq(rstEvtReq), .hwErrReq(hwErrReq),
    .coreTimerReq(coreTimerReq), .excReq(excReq), .swRaise(swRaise), .swRaiseLvl(swRaiseLvl),
    .globalEnable(globalEnable), .takeAck(takeAck), .curPc(curPc), .retStrobe(retStrobe),
    .retEvt(retEvt), .take(take), .commitHold(commitHold), .emuMode(emuMode),
    .returnValid(returnValid), .returnAddr(returnAddr), .pendingOut(pendingOut),
    .latchOut(latchOut), .supervisor(supervisor), .periphAccess(periphAccess),
    .cfgReq(cfgReq), .cfgRdData(cfgRdData), .cfgDenied(cfgDenied), .perStatus(perStatus),
    .gpLevels(gpLevels));

  tsec_seq_model i_seq (.clk(clk), .reset_n(reset_n), .slow(slow), .take(take),
    .takeAck(takeAck), .curPc(curPc));

  always #50 clk = ~clk;

  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cfg(input logic wr, input tsec_cfg_sel_t sel, input logic [5:0] idx,
                     input logic [31:0] d);
    @(posedge clk) cfgReq <= '{wr, !wr, sel, idx, d};
    @(posedge clk) cfgReq <= '0;
    #1;
  endtask : cfg

  task automatic srcChk(input logic [5:0] src, input logic [8:0] gp);
    @(posedge clk) perSrc <= 48'h1 << src;
    @(posedge clk) perSrc <= '0;
    #1;
    chk("gpLevels", {23'h0, gp}, {23'h0, gpLevels});
    chk("perStatus", 32'h1, {31'h0, perStatus == (48'h1 << src)});
    repeat (2) @(posedge clk);
  endtask : srcChk

  task automatic pulse(input logic [7:0] k);
    @(posedge clk) kick <= k;
    @(posedge clk) kick <= '0;
  endtask : pulse

  task automatic waitPend(input logic [3:0] e);
    int n = 0;
    #1;
    while (pendingOut[e] !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("pending", 32'h1, {31'h0, pendingOut[e]});
  endtask : waitPend

  task automatic ret(input logic [3:0] e);
    @(posedge clk) begin
      retStrobe <= 1'b1;
      retEvt <= e;
    end
    @(posedge clk) retStrobe <= 1'b0;
    #1;
    chk("returnValid", 32'h1, {31'h0, returnValid});
    chk("returnAddr", 32'hC0DE_0000 | e, returnAddr);
  endtask : ret

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      results();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk("pendingOut", 32'h0, {16'h0, pendingOut});
    chk("latchOut", 32'h0, {16'h0, latchOut});
    chk("cfgRdData", 32'h0, cfgRdData);
    cfg(1'b0, SEL_CMASK, 6'h00, 32'h0);
    chk("cmask", 32'h0000_000F, cfgRdData);
    chk("cfgDenied", 32'h0, {31'h0, cfgDenied});
    cfg(1'b1, SEL_PMASK, 6'h00, 32'hFFFF_FFFF);
    cfg(1'b1, SEL_PMASK, 6'h01, 32'h0000_FFFF);
    // a level below 7 must be ignored, so row 0 still lands on level 7
    cfg(1'b1, SEL_ASSIGN, 6'h00, 32'h0000_0006);
    foreach (rows[i]) begin
      srcChk(rows[i].src, rows[i].gp);
    end
    cfg(1'b1, SEL_PMASK, 6'h01, 32'h0000_7FFF);
    srcChk(6'h2F, 9'h000);
    cfg(1'b1, SEL_PMASK, 6'h01, 32'h0000_FFFF);
    cfg(1'b1, SEL_ASSIGN, 6'h2F, 32'h0000_000F);
    srcChk(6'h2F, 9'h100);
    @(posedge clk) periphAccess <= 1'b1;
    cfg(1'b1, SEL_ASSIGN, 6'h00, 32'h0000_000F);
    chk("cfgDenied", 32'h1, {31'h0, cfgDenied});
    @(posedge clk) periphAccess <= 1'b0;
    srcChk(6'h00, 9'h001);
    cfg(1'b1, SEL_LATCH, 6'h00, 32'h0000_FFFF);
    chk("latchOut", 32'h0, {16'h0, latchOut});
    cfg(1'b1, SEL_CMASK, 6'h00, 32'h0000_FFFF);
    @(posedge clk) globalEnable <= 1'b1;
    cfg(1'b0, SEL_CMASK, 6'h00, 32'h0);
    chk("cmask", 32'h0000_FFEF, cfgRdData);
    // level 15 stands for a software handler
    foreach (evts[i]) begin
      pulse(8'h01 << i);
      if (i == 4) begin
        #1;
        chk("commitHold", 32'h1, {31'h0, commitHold});
      end
      waitPend(evts[i]);
      if (i == 0) begin
        chk("emuMode", 32'h1, {31'h0, emuMode});
      end
      ret(evts[i]);
      if (i == 4) begin
        chk("commitHold", 32'h0, {31'h0, commitHold});
      end
    end
    @(posedge clk) begin
      slow <= 1'b1;
      swRaiseLvl <= 4'hC;
    end
    pulse(8'h90);
    waitPend(4'h3);
    chk("lowerHeld", 32'h1, {30'h0, pendingOut[12], latchOut[12]});
    ret(4'h3);
    waitPend(4'hC);
    pulse(8'h01);
    waitPend(4'h0);
    chk("nested", 32'h0000_1001, {16'h0, pendingOut});
    ret(4'h0);
    chk("emuMode", 32'h0, {31'h0, emuMode});
    ret(4'hC);
    // a peripheral edge must not reach pending within three cycles
    @(posedge clk) perSrc <= 48'h1;
    repeat (3) @(posedge clk);
    #1;
    chk("earlyPend", 32'h0, {31'h0, pendingOut[7]});
    waitPend(4'h7);
    @(posedge clk) perSrc <= '0;
    ret(4'h7);
    results();
  end
endmodule : tsec_event_ctrl_bench
